// [shared/sbw_pkg.sv]
// Package for the serial break, wake and synchronous master block.
// Assumes a 10 MHz system clock and an Avalon-MM register slave.
package sbw_pkg;
	localparam int unsigned CLK_HZ = 10000000;
	localparam logic [3:0] OFS_TRANSMIT_STATUS_CONTROL_REG = 4'h0;
	localparam logic [3:0] OFS_RECEIVE_STATUS_CONTROL_REG = 4'h4;
	localparam logic [3:0] OFS_BAUD = 4'h8;
	localparam logic [3:0] OFS_TXDATA = 4'hC;
	localparam logic [4:0] OFS_RXDATA = 5'h10;
	localparam logic [4:0] OFS_BRG = 5'h14;
	// Transmit control fields
	localparam int TX_CLOCK_SOURCE_MASTER = 7;
	localparam int TX_TRANSMIT_ENABLE_BIT = 5;
	localparam int TX_SYNC = 4;
	localparam int TX_SEND_BREAK_REQUEST = 3;
	localparam int TX_SHIFT_EMPTY_STATUS = 1;
	localparam int TX_TRANSMIT_BUFFER_EMPTY_FLAG = 0;
	// Receive control fields
	localparam int RC_PORT_ENABLE = 7;
	localparam int RC_SINGLE_RECEIVE_ENABLE = 5;
	localparam int RC_CONTINUOUS_RECEIVE_ENABLE = 4;
	localparam int RC_FRAMING_ERROR_BIT = 2;
	localparam int RC_RECEIVE_FLAG = 0;
	// Baud control fields
	localparam int BD_RECEIVER_IDLE_STATUS = 6;
	localparam int BD_CLOCK_POLARITY_SELECT = 4;
	localparam int BD_WUE = 1;
	localparam logic [15:0] BRG_RESET = 16'h0009;
	localparam logic [3:0] BREAK_ZEROS = 4'hC;
	localparam logic [3:0] ASYNC_BITS = 4'h9;
	localparam logic [3:0] SYNC_BITS = 4'h8;
	typedef struct packed {
		logic clock_source_master;
		logic transmit_enable_bit;
		logic sync;
		logic send_break_request;
	} sbw_txctl_t;
	typedef struct packed {
		logic port_enable;
		logic single_receive_enable;
		logic continuous_receive_enable;
	} sbw_rxctl_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ASYNC = 4'b0010,
		ST_SYNC = 4'b0100,
		ST_WAIT = 4'b1000
	} sbw_txst_t;
endpackage

// [rtl/sbw_top.sv]
// Serial port slice: wake on receive edge, break send and detect, sync master transmit.
// Assumes Avalon-MM master on mclk_i; receive pin is asynchronous and synchronised here.
module sbw_top (
	input wire logic mclk_i, // System clock
	input wire logic reset_n_i, // Async reset, active low
	input wire logic [4:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read strobe
	input wire logic avs_write_i, // Write strobe
	input wire logic [31:0] avs_writedata_i, // Write data
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Stall
	input wire logic receive_data_pin_i, // Data pin level in
	output logic receive_data_pin_o, // Data pin drive
	output logic receive_data_pin_oe_o, // Data pin enable
	output logic transmit_clock_pin_o, // TX or clock pin drive
	output logic transmit_clock_pin_oe_o // TX or clock pin enable
);
	logic rx_s1_reg, rx_s2_reg, rx_prev_reg;
	sbw_pkg::sbw_txctl_t txc_reg;
	sbw_pkg::sbw_rxctl_t rxc_reg;
	logic clock_polarity_select_reg, wue_reg, framing_error_bit_reg, receive_flag_reg, transmit_buffer_empty_flag_reg, shift_empty_status_reg;
	logic [15:0] brg_reg;
	logic [7:0] txbuf_reg, shifter_reg, rxdata_reg;
	logic brk_pending_reg, brk_active_reg;
	sbw_pkg::sbw_txst_t st_reg;
	logic [15:0] baud_cnt_reg;
	logic [3:0] bit_cnt_reg;
	logic half_reg;
	logic [31:0] rdata_reg;
	logic wait_reg, wreq_reg;
	logic txd_reg, txoe_reg, dt_reg, dtoe_reg;
	logic [1:0] rx_st_reg;
	logic [15:0] rx_cnt_reg;
	logic [3:0] rx_bits_reg;
	logic rx_idle_reg;

	logic rx_fall, rx_rise, acc, wr, rd, tick;
	logic sync_master_tx, async_tx;
	assign rx_fall = rx_prev_reg & ~rx_s2_reg;
	assign rx_rise = ~rx_prev_reg & rx_s2_reg;
	assign acc = (avs_read_i | avs_write_i) & wait_reg;
	assign wr = avs_write_i & wait_reg;
	assign rd = avs_read_i & wait_reg;
	assign tick = (baud_cnt_reg == 16'h0000);
	assign sync_master_tx = txc_reg.sync & txc_reg.clock_source_master & rxc_reg.port_enable & ~rxc_reg.single_receive_enable & ~rxc_reg.continuous_receive_enable;
	assign async_tx = ~txc_reg.sync & rxc_reg.port_enable;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
		return a == o;
	endfunction

	// Two-flop synchroniser, then an edge register
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_s1_reg <= receive_data_pin_i;
			rx_s2_reg <= rx_s1_reg;
			rx_prev_reg <= rx_s2_reg;
		end
	end

	// One wait state: answer at the second edge of each access
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wait_reg <= 1'b0;
			wreq_reg <= 1'b1;
			rdata_reg <= 32'h00000000;
		end else begin
			wait_reg <= (avs_read_i | avs_write_i) & ~wait_reg;
			wreq_reg <= ~((avs_read_i | avs_write_i) & ~wait_reg);
			// Read data captured a cycle early so it stands at the taking edge
			if (avs_read_i && !wait_reg) begin
				unique case (avs_address_i)
					{1'b0, sbw_pkg::OFS_TRANSMIT_STATUS_CONTROL_REG}: rdata_reg <= {24'h000000, txc_reg.clock_source_master, 1'b0, txc_reg.transmit_enable_bit,
						txc_reg.sync, txc_reg.send_break_request, 1'b0, shift_empty_status_reg, transmit_buffer_empty_flag_reg};
					{1'b0, sbw_pkg::OFS_RECEIVE_STATUS_CONTROL_REG}: rdata_reg <= {24'h000000, rxc_reg.port_enable, 1'b0, rxc_reg.single_receive_enable,
						rxc_reg.continuous_receive_enable, 1'b0, framing_error_bit_reg, 1'b0, receive_flag_reg};
					{1'b0, sbw_pkg::OFS_BAUD}: rdata_reg <= {24'h000000, 1'b0, rx_idle_reg, 1'b0, clock_polarity_select_reg,
						2'b00, wue_reg, 1'b0};
					sbw_pkg::OFS_RXDATA: rdata_reg <= {24'h000000, rxdata_reg};
					sbw_pkg::OFS_BRG: rdata_reg <= {16'h0000, brg_reg};
					default: rdata_reg <= 32'h00000000; // Data register and unmapped read zero
				endcase
			end
		end
	end
	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wreq_reg;

	// Control bits; hardware clears win only when no write coincides
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			txc_reg <= '0;
			rxc_reg <= '0;
			clock_polarity_select_reg <= 1'b0;
			wue_reg <= 1'b0;
			brg_reg <= sbw_pkg::BRG_RESET;
		end else begin
			if (wr && hit(avs_address_i, {1'b0, sbw_pkg::OFS_TRANSMIT_STATUS_CONTROL_REG})) begin
				txc_reg.clock_source_master <= avs_writedata_i[sbw_pkg::TX_CLOCK_SOURCE_MASTER];
				txc_reg.transmit_enable_bit <= avs_writedata_i[sbw_pkg::TX_TRANSMIT_ENABLE_BIT];
				txc_reg.sync <= avs_writedata_i[sbw_pkg::TX_SYNC];
				txc_reg.send_break_request <= avs_writedata_i[sbw_pkg::TX_SEND_BREAK_REQUEST];
			end else if (brk_active_reg && st_reg == sbw_pkg::ST_ASYNC && tick && bit_cnt_reg == 4'h0) begin
				txc_reg.send_break_request <= 1'b0;
			end
			if (wr && hit(avs_address_i, {1'b0, sbw_pkg::OFS_RECEIVE_STATUS_CONTROL_REG})) begin
				rxc_reg.port_enable <= avs_writedata_i[sbw_pkg::RC_PORT_ENABLE];
				rxc_reg.single_receive_enable <= avs_writedata_i[sbw_pkg::RC_SINGLE_RECEIVE_ENABLE];
				rxc_reg.continuous_receive_enable <= avs_writedata_i[sbw_pkg::RC_CONTINUOUS_RECEIVE_ENABLE];
			end
			if (wr && hit(avs_address_i, {1'b0, sbw_pkg::OFS_BAUD})) begin
				clock_polarity_select_reg <= avs_writedata_i[sbw_pkg::BD_CLOCK_POLARITY_SELECT];
				wue_reg <= avs_writedata_i[sbw_pkg::BD_WUE] & ~txc_reg.sync;
			end else if (wue_reg && (rx_rise || txc_reg.sync)) begin
				wue_reg <= 1'b0;
			end
			if (wr && hit(avs_address_i, sbw_pkg::OFS_BRG))
				brg_reg <= avs_writedata_i[15:0];
		end
	end

	// Asynchronous receiver: start, 8 data, stop; held idle while wake armed
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_st_reg <= 2'b00;
			rx_cnt_reg <= 16'h0000;
			rx_bits_reg <= 4'h0;
			rxdata_reg <= 8'h00;
			receive_flag_reg <= 1'b0;
			framing_error_bit_reg <= 1'b0;
			rx_idle_reg <= 1'b1;
		end else begin
			if (rd && hit(avs_address_i, sbw_pkg::OFS_RXDATA))
				receive_flag_reg <= 1'b0;
			if (wue_reg || !rxc_reg.port_enable || txc_reg.sync || !rxc_reg.continuous_receive_enable) begin
				rx_st_reg <= 2'b00;
				rx_idle_reg <= 1'b1;
				if (wue_reg && rx_fall)
					receive_flag_reg <= 1'b1;
			end else if (rx_st_reg == 2'b00) begin
				if (rx_fall) begin
					rx_st_reg <= 2'b01;
					rx_idle_reg <= 1'b0;
					rx_cnt_reg <= {1'b0, brg_reg[15:1]};
					rx_bits_reg <= 4'h0;
				end
			end else if (rx_cnt_reg != 16'h0000) begin
				rx_cnt_reg <= rx_cnt_reg - 16'h0001;
			end else begin
				rx_cnt_reg <= brg_reg;
				rx_bits_reg <= rx_bits_reg + 4'h1;
				if (rx_bits_reg != 4'h0 && rx_bits_reg < sbw_pkg::ASYNC_BITS)
					rxdata_reg <= {rx_s2_reg, rxdata_reg[7:1]};
				if (rx_bits_reg == sbw_pkg::ASYNC_BITS) begin
					framing_error_bit_reg <= ~rx_s2_reg;
					receive_flag_reg <= 1'b1;
					rx_st_reg <= 2'b00;
					rx_idle_reg <= 1'b1;
				end
			end
		end
	end

	// Transmit buffer and shifter; shifter has no register address
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			txbuf_reg <= 8'h00;
			transmit_buffer_empty_flag_reg <= 1'b1;
			shift_empty_status_reg <= 1'b1;
			brk_pending_reg <= 1'b0;
			brk_active_reg <= 1'b0;
			shifter_reg <= 8'h00;
			st_reg <= sbw_pkg::ST_IDLE;
			baud_cnt_reg <= 16'h0000;
			bit_cnt_reg <= 4'h0;
			half_reg <= 1'b0;
			txd_reg <= 1'b1;
			txoe_reg <= 1'b0;
			dt_reg <= 1'b0;
			dtoe_reg <= 1'b0;
		end else begin
			if (wr && hit(avs_address_i, {1'b0, sbw_pkg::OFS_TXDATA}) && txc_reg.transmit_enable_bit) begin
				txbuf_reg <= avs_writedata_i[7:0];
				transmit_buffer_empty_flag_reg <= 1'b0;
				brk_pending_reg <= txc_reg.send_break_request & ~brk_active_reg & ~txc_reg.sync;
			end
			txoe_reg <= (async_tx & txc_reg.transmit_enable_bit) | (txc_reg.sync & txc_reg.clock_source_master & rxc_reg.port_enable);
			dtoe_reg <= sync_master_tx & txc_reg.transmit_enable_bit;
			baud_cnt_reg <= tick ? brg_reg : baud_cnt_reg - 16'h0001;
			unique case (st_reg)
				sbw_pkg::ST_IDLE: begin
					shift_empty_status_reg <= 1'b1;
					txd_reg <= sync_master_tx ? clock_polarity_select_reg : 1'b1;
					if (!transmit_buffer_empty_flag_reg && txc_reg.transmit_enable_bit && (async_tx || sync_master_tx)) begin
						shifter_reg <= brk_pending_reg ? 8'h00 : txbuf_reg;
						brk_active_reg <= brk_pending_reg;
						brk_pending_reg <= 1'b0;
						transmit_buffer_empty_flag_reg <= 1'b1;
						shift_empty_status_reg <= 1'b0;
						baud_cnt_reg <= brg_reg;
						half_reg <= 1'b0;
						if (async_tx) begin
							txd_reg <= 1'b0;
							bit_cnt_reg <= brk_pending_reg ? sbw_pkg::BREAK_ZEROS + 4'h1 : sbw_pkg::ASYNC_BITS;
							st_reg <= sbw_pkg::ST_ASYNC;
						end else begin
							dt_reg <= txbuf_reg[0];
							txd_reg <= ~clock_polarity_select_reg;
							shifter_reg <= {1'b0, txbuf_reg[7:1]};
							bit_cnt_reg <= sbw_pkg::SYNC_BITS;
							st_reg <= sbw_pkg::ST_SYNC;
						end
					end
				end
				sbw_pkg::ST_ASYNC: if (tick) begin
					if (bit_cnt_reg == 4'h0) begin
						brk_active_reg <= 1'b0;
						st_reg <= sbw_pkg::ST_IDLE;
					end else begin
						bit_cnt_reg <= bit_cnt_reg - 4'h1;
						txd_reg <= (bit_cnt_reg == 4'h1) ? 1'b1 : shifter_reg[0];
						shifter_reg <= {1'b0, shifter_reg[7:1]};
					end
				end
				sbw_pkg::ST_SYNC: if (tick) begin
					half_reg <= ~half_reg;
					if (!half_reg) begin
						txd_reg <= clock_polarity_select_reg; // Trailing edge
						bit_cnt_reg <= bit_cnt_reg - 4'h1;
					end else if (bit_cnt_reg != 4'h0) begin
						txd_reg <= ~clock_polarity_select_reg;
						dt_reg <= shifter_reg[0];
						shifter_reg <= {1'b0, shifter_reg[7:1]};
					end else begin
						st_reg <= sbw_pkg::ST_WAIT;
					end
				end
				sbw_pkg::ST_WAIT: begin
					st_reg <= sbw_pkg::ST_IDLE;
				end
				default: st_reg <= sbw_pkg::ST_IDLE;
			endcase
		end
	end
	assign transmit_clock_pin_o = txd_reg;
	assign transmit_clock_pin_oe_o = txoe_reg;
	assign receive_data_pin_o = dt_reg;
	assign receive_data_pin_oe_o = dtoe_reg;

	property p_wake_flag;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(wue_reg && rx_fall && !(rd && hit(avs_address_i, sbw_pkg::OFS_RXDATA))) |=> receive_flag_reg;
	endproperty
	a_wake_flag: assert property (p_wake_flag) else $error("wake edge did not set flag");

	property p_wake_clear;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(wue_reg && rx_rise && !wr) |=> !wue_reg;
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("wake enable not cleared");

	property p_rx_held;
		@(posedge mclk_i) disable iff (!reset_n_i)
		wue_reg |=> rx_idle_reg;
	endproperty
	a_rx_held: assert property (p_rx_held) else $error("receiver active while wake armed");

	property p_no_wake_sync;
		@(posedge mclk_i) disable iff (!reset_n_i)
		txc_reg.sync |=> !wue_reg;
	endproperty
	a_no_wake_sync: assert property (p_no_wake_sync) else $error("wake armed in sync mode");

	property p_shift_empty_status;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(st_reg != sbw_pkg::ST_IDLE && $past(st_reg) != sbw_pkg::ST_IDLE) |-> !shift_empty_status_reg;
	endproperty
	a_shift_empty_status: assert property (p_shift_empty_status) else $error("shift empty while sending");

	logic tx_launch;
	assign tx_launch = st_reg == sbw_pkg::ST_IDLE && !transmit_buffer_empty_flag_reg && txc_reg.transmit_enable_bit && (async_tx || sync_master_tx);

	property p_transmit_buffer_empty_flag;
		@(posedge mclk_i) disable iff (!reset_n_i)
		tx_launch |=> transmit_buffer_empty_flag_reg;
	endproperty
	a_transmit_buffer_empty_flag: assert property (p_transmit_buffer_empty_flag) else $error("buffer empty flag not raised");

	property p_send_break_request;
		@(posedge mclk_i) disable iff (!reset_n_i)
		$fell(brk_active_reg) |-> !txc_reg.send_break_request;
	endproperty
	a_send_break_request: assert property (p_send_break_request) else $error("send break not cleared");

	property p_clk_idle;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(sync_master_tx && $past(sync_master_tx) && $stable(clock_polarity_select_reg) && st_reg == sbw_pkg::ST_IDLE
			&& $past(st_reg) == sbw_pkg::ST_IDLE) |-> txd_reg == clock_polarity_select_reg;
	endproperty
	a_clk_idle: assert property (p_clk_idle) else $error("clock idle level wrong");

	property p_dt_stable;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(st_reg == sbw_pkg::ST_SYNC && $changed(txd_reg) && txd_reg == clock_polarity_select_reg) |-> $stable(dt_reg);
	endproperty
	a_dt_stable: assert property (p_dt_stable) else $error("data moved on trailing edge");

	// Launch steps: the first bit leaves with the transfer
	sequence s_sync_launch;
		tx_launch && sync_master_tx;
	endsequence
	sequence s_sync_first_bit;
		st_reg == sbw_pkg::ST_SYNC && half_reg == 1'b0;
	endsequence
	property p_sync_launch;
		@(posedge mclk_i) disable iff (!reset_n_i)
		s_sync_launch |=> s_sync_first_bit ##0 dt_reg == $past(txbuf_reg[0]);
	endproperty
	a_sync_launch: assert property (p_sync_launch) else $error("sync shift did not start");

	sequence s_break_launch;
		tx_launch && async_tx && brk_pending_reg;
	endsequence
	property p_break_start;
		@(posedge mclk_i) disable iff (!reset_n_i)
		s_break_launch |=> !txd_reg && brk_active_reg && bit_cnt_reg == sbw_pkg::BREAK_ZEROS + 4'h1;
	endproperty
	a_break_start: assert property (p_break_start) else $error("break did not start low");

	property p_break_stop;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(st_reg == sbw_pkg::ST_ASYNC && tick && bit_cnt_reg == 4'h1) |=> txd_reg;
	endproperty
	a_break_stop: assert property (p_break_stop) else $error("stop bit not high");

	property p_send_break_request_hold;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(brk_active_reg && txc_reg.send_break_request && !(tick && bit_cnt_reg == 4'h0) && !wr) |=> txc_reg.send_break_request;
	endproperty
	a_send_break_request_hold: assert property (p_send_break_request_hold) else $error("send break cleared early");

	property p_master_clk_oe;
		@(posedge mclk_i) disable iff (!reset_n_i)
		sync_master_tx |=> transmit_clock_pin_oe_o;
	endproperty
	a_master_clk_oe: assert property (p_master_clk_oe) else $error("clock driver off as master");

	property p_break_rx;
		@(posedge mclk_i) disable iff (!reset_n_i)
		(!(wue_reg || !rxc_reg.port_enable || txc_reg.sync || !rxc_reg.continuous_receive_enable) && rx_st_reg == 2'b01
			&& rx_cnt_reg == 16'h0000 && rx_bits_reg == sbw_pkg::ASYNC_BITS && !rx_s2_reg) |=> framing_error_bit_reg && receive_flag_reg;
	endproperty
	a_break_rx: assert property (p_break_rx) else $error("low stop bit not flagged");

	property p_wait_answer;
		@(posedge mclk_i) disable iff (!reset_n_i)
		((avs_read_i || avs_write_i) && !wait_reg) |=> !avs_waitrequest_o;
	endproperty
	a_wait_answer: assert property (p_wait_answer) else $error("bus access not answered");

	property p_wait_single;
		@(posedge mclk_i) disable iff (!reset_n_i)
		!avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	a_wait_single: assert property (p_wait_single) else $error("wait request low twice");
endmodule

// [verif/sbw_far_node.sv]
// Far-side model: remote async node on the receive line, sync slave on clock and data.
// Assumes an 800 ns async bit time; the bench selects the master clock polarity.
module sbw_far_node (
	input wire logic ck_i, // TX line or master clock
	input wire logic dt_i, // Shared data line
	input wire logic pol_i, // Idle level of master clock
	output logic line_o // Drive onto receive line
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT_NS = 800;
	logic [15:0] sr;
	int n_bits;
	initial begin
		line_o = 1'b1;
		sr = 16'h0000;
		n_bits = 0;
	end
	// Trailing edge returns to idle level; data must be settled there
	always @(ck_i) begin
		if (ck_i === pol_i) begin
			sr = {dt_i, sr[15:1]};
			n_bits++;
		end
	end
	// Wake or break: all zeros, held low for n bit times
	task send_low(input int n);
		line_o = 1'b0;
		#(n * BIT_NS);
		line_o = 1'b1;
	endtask
	task send_byte(input logic [7:0] b);
		line_o = 1'b0;
		for (int k = 0; k < 8; k++) begin
			#BIT_NS;
			line_o = b[k];
		end
		#BIT_NS;
		line_o = 1'b1;
		#BIT_NS;
	endtask
	// Low span of the first frame, then one byte sampled mid-bit
	task rx_frame(output longint low_ns, output logic [7:0] b);
		longint t;
		@(negedge ck_i);
		t = $time;
		@(posedge ck_i);
		low_ns = $time - t;
		@(negedge ck_i);
		#(BIT_NS / 2);
		repeat (8) begin
			#BIT_NS;
			b = {ck_i, b[7:1]};
		end
	endtask
endmodule

// [verif/sbw_top_bench.sv]
// Bench: sync master rows, break send and receive, wake on edge.
// Assumes brg set to 7, so one async bit is 8 clocks and one sync bit 16.
module sbw_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i, reset_n_i, avs_read_i, avs_write_i;
	logic [4:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic avs_waitrequest_o, dt_o, dt_oe, ck_o, ck_oe, line, pol;
	logic [7:0] got;
	longint low_ns;
	int fails, n_tests;
	logic [8:0] rows [4] = '{9'h0A5, 9'h13C, 9'h001, 9'h1FE};
	sbw_top uut (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.receive_data_pin_i(dt_oe ? dt_o : line), .receive_data_pin_o(dt_o),
		.receive_data_pin_oe_o(dt_oe), .transmit_clock_pin_o(ck_o), .transmit_clock_pin_oe_o(ck_oe)
	);
	sbw_far_node node (.ck_i(ck_o), .dt_i(dt_oe ? dt_o : line), .pol_i(pol), .line_o(line));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One edge gap between accesses so no strobe is assigned twice in a step
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_address_i <= a;
		avs_writedata_i <= d;
		do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	// Extra clocks after the last bit expose any surplus clock cycles
	task wait_bits(input int n);
		for (int k = 0; k < 800 && node.n_bits < n; k++) @(posedge mclk_i);
		repeat (60) @(posedge mclk_i);
	endtask
	task results;
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		#5000000;
		fails++;
		results();
	end
	initial begin
		reset_n_i = 1'b0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_address_i = 5'h00;
		avs_writedata_i = 32'h0;
		pol = 1'b0;
		fails = 0;
		n_tests = 0;
		repeat (5) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		bus(1'b0, 5'h00, 32'h0);
		chk(rd[1:0], 2'h3);
		bus(1'b0, 5'h18, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 5'h14, 32'h7);
		$display("test reset done");
		bus(1'b1, 5'h04, 32'h80);
		bus(1'b1, 5'h00, 32'hB0);
		for (int i = 0; i < 4; i++) begin
			pol = rows[i][8];
			bus(1'b1, 5'h08, {27'h0, pol, 4'h0});
			repeat (2) @(posedge mclk_i);
			node.n_bits = 0;
			chk(ck_o, pol);
			bus(1'b1, 5'h0C, {24'h0, rows[i][7:0]});
			wait_bits(8);
			chk(node.sr[15:8], rows[i][7:0]);
			chk(32'(node.n_bits), 32'h8);
			chk({dt_oe, ck_oe, ck_o}, {2'h3, pol});
		end
		$display("test sync rows done");
		node.n_bits = 0;
		bus(1'b1, 5'h0C, 32'h5A);
		bus(1'b1, 5'h0C, 32'hC3);
		wait_bits(16);
		chk(node.sr, 16'hC35A);
		chk(32'(node.n_bits), 32'h10);
		bus(1'b1, 5'h08, 32'h02);
		bus(1'b0, 5'h08, 32'h0);
		chk(rd[1], 1'b0);
		$display("test sync back to back done");
		bus(1'b1, 5'h00, 32'h28);
		repeat (4) @(posedge mclk_i);
		fork
			node.rx_frame(low_ns, got);
			begin
				bus(1'b1, 5'h0C, 32'hAA);
				bus(1'b1, 5'h0C, 32'h55);
				bus(1'b0, 5'h00, 32'h0);
				chk({rd[3], rd[1]}, 2'h2);
			end
		join
		chk(32'(low_ns), 32'h28A0);
		chk(got, 8'h55);
		repeat (20) @(posedge mclk_i);
		bus(1'b0, 5'h00, 32'h0);
		chk({rd[3], rd[1], rd[0]}, 3'h3);
		$display("test break send done");
		bus(1'b1, 5'h04, 32'h90);
		bus(1'b0, 5'h08, 32'h0);
		chk(rd[6], 1'b1);
		bus(1'b1, 5'h08, 32'h02);
		fork
			node.send_low(13);
			begin
				repeat (30) @(posedge mclk_i);
				bus(1'b0, 5'h04, 32'h0);
				chk(rd[0], 1'b1);
				bus(1'b0, 5'h08, 32'h0);
				chk(rd[1], 1'b1);
			end
		join
		repeat (10) @(posedge mclk_i);
		bus(1'b0, 5'h08, 32'h0);
		chk(rd[1], 1'b0);
		bus(1'b0, 5'h10, 32'h0);
		bus(1'b0, 5'h04, 32'h0);
		chk({rd[2], rd[0]}, 2'h0);
		node.send_byte(8'h55);
		bus(1'b0, 5'h04, 32'h0);
		chk(rd[0], 1'b1);
		bus(1'b0, 5'h10, 32'h0);
		chk(rd[7:0], 8'h55);
		$display("test wake done");
		node.send_low(13);
		repeat (20) @(posedge mclk_i);
		bus(1'b0, 5'h04, 32'h0);
		chk({rd[2], rd[0]}, 2'h3);
		bus(1'b0, 5'h10, 32'h0);
		chk(rd[7:0], 8'h00);
		$display("test break receive done");
		results();
	end
endmodule
